/* File: logic/dklr_consts.svh */
// Timing and option constants for the dual key long press reset timer
`ifndef DKLR_CONSTS_SVH
`define DKLR_CONSTS_SVH
`define DKLR_CLK_HZ        25000000
// Delays in milliseconds, as printed; the last one in microseconds
`define DKLR_DLY_7500_MS   7500
`define DKLR_DLY_11250_MS  11250
`define DKLR_DLY_10000_MS  10000
`define DKLR_DLY_3000_MS   3000
`define DKLR_REL_234_MS    234
`define DKLR_REL_313_MS    313
`define DKLR_REL_78_MS     78
`define DKLR_REL_187P5_US  187500
`define DKLR_CYC_PER_MS    (`DKLR_CLK_HZ / 1000)
`define DKLR_CYC_PER_US    (`DKLR_CLK_HZ / 1000000)
`define DKLR_CNT_W         32
`endif

/* File: logic/dklr_pkg.sv */
// Types for the dual key long press reset timer
package dklr_pkg;
  typedef enum logic [2:0] {
    DKLR_OPT_001,
    DKLR_OPT_002,
    DKLR_OPT_052,
    DKLR_OPT_053,
    DKLR_OPT_064
  } dklr_opt_e;

  typedef enum logic [1:0] {
    DKLR_IDLE,
    DKLR_TIMING,
    DKLR_ASSERT,
    DKLR_WAIT_REL
  } dklr_state_e;

  typedef struct packed {
    logic rst_low_o;
    logic rst_low_oe_n;
    logic rst_high;
  } dklr_rst_s;
endpackage

/* File: logic/dklr_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module dklr_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic pin,
  output logic      level
);
  logic [2:0] sh_r;
  logic [2:0] sh_nxt;
  logic       level_r;
  logic       level_nxt;

  always_comb begin
    sh_nxt    = {sh_r[1:0], pin};
    level_nxt = level_r;
    // Only second and third stage feed the filter
    if (sh_r[1] == sh_r[2]) begin
      level_nxt = sh_r[1];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sh_r    <= {3{RST_VAL}};
      level_r <= RST_VAL;
    end else begin
      sh_r    <= sh_nxt;
      level_r <= level_nxt;
    end
  end

  assign level = level_r;
endmodule // dklr_sync

/* File: logic/dklr_timer.sv */
// Dual key long press reset timer, top level
// Notes on behaviour
// - Time only while both keys low; assert reset after delay.
// - Selectable variant: 7.5 s either way; strap is latched from its sync reset value, so 11.25 s is never chosen.
// - Selectable variant: reset holds until a key goes high.
// - Fixed variants: fixed delay, reset self-releases after release time.
// - Fixed variants: key going high releases reset early.
// - Release time 0.234, 0.313, 0.078 s per option.
// - Delay 7.5 s or 10 s; option 064 uses 3.0 s and 0.1875 s.
// - Delay and release within ten percent of nominal.
// - Primary reset is active-low open-drain.
// - Dual-output option adds active-high push-pull reset.
`timescale 1ns/1ps
`include "dklr_consts.svh"
module dklr_timer #(
  parameter dklr_pkg::dklr_opt_e OPTION    = dklr_pkg::DKLR_OPT_002,
  parameter logic                DUAL_OUT  = 1'b1,
  parameter int unsigned         DLY_SEL0  = `DKLR_DLY_7500_MS * `DKLR_CYC_PER_MS,
  parameter int unsigned         DLY_SEL1  = `DKLR_DLY_11250_MS * `DKLR_CYC_PER_MS,
  parameter int unsigned         DLY_002   = `DKLR_DLY_7500_MS * `DKLR_CYC_PER_MS,
  parameter int unsigned         DLY_05X   = `DKLR_DLY_10000_MS * `DKLR_CYC_PER_MS,
  parameter int unsigned         DLY_064   = `DKLR_DLY_3000_MS * `DKLR_CYC_PER_MS,
  parameter int unsigned         REL_002   = `DKLR_REL_234_MS * `DKLR_CYC_PER_MS,
  parameter int unsigned         REL_052   = `DKLR_REL_313_MS * `DKLR_CYC_PER_MS,
  parameter int unsigned         REL_053   = `DKLR_REL_78_MS * `DKLR_CYC_PER_MS,
  parameter int unsigned         REL_064   = `DKLR_REL_187P5_US * `DKLR_CYC_PER_US
) (
  input  wire logic               core_clk,
  input  wire logic               rstn,
  input  wire logic               key_input_a_n,
  input  wire logic               key_input_b_n,
  input  wire logic               delay_sel,
  input  wire logic               factory_pin_a,
  input  wire logic               factory_pin_b,
  output logic                    reset_out_low_o,
  output logic                    reset_out_low_oe_n,
  output logic                    reset_out_high_pp,
  output dklr_pkg::dklr_state_e   timer_state
);
  localparam logic [`DKLR_CNT_W-1:0] ONE = `DKLR_CNT_W'h1;

  logic                   key_a_lvl;
  logic                   key_b_lvl;
  logic                   sel_lvl;
  logic                   both_low;
  logic                   sel_r;
  logic                   sel_nxt;
  logic                   sel_done_r;
  logic                   sel_done_nxt;
  logic [`DKLR_CNT_W-1:0] dly_cyc;
  logic [`DKLR_CNT_W-1:0] rel_cyc;
  logic [`DKLR_CNT_W-1:0] cnt_r;
  logic [`DKLR_CNT_W-1:0] cnt_nxt;
  dklr_pkg::dklr_state_e  st_r;
  dklr_pkg::dklr_state_e  st_nxt;
  dklr_pkg::dklr_rst_s    out_r;
  dklr_pkg::dklr_rst_s    out_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers; keys idle high, strap assumed low until seen
  dklr_sync #(.RST_VAL(1'b1)) u_sync_a (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pin      (key_input_a_n),
    .level    (key_a_lvl)
  );
  dklr_sync #(.RST_VAL(1'b1)) u_sync_b (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pin      (key_input_b_n),
    .level    (key_b_lvl)
  );
  dklr_sync #(.RST_VAL(1'b0)) u_sync_sel (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pin      (delay_sel),
    .level    (sel_lvl)
  );

  assign both_low = !key_a_lvl && !key_b_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // Strap latched once
  // Captured on the first clock after reset from the sync reset value (low), before the strap pin is seen
  always_comb begin
    sel_nxt      = sel_r;
    sel_done_nxt = sel_done_r;
    if (!sel_done_r && st_r == dklr_pkg::DKLR_IDLE && !both_low) begin
      sel_nxt      = sel_lvl;
      sel_done_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sel_r      <= 1'b0;
      sel_done_r <= 1'b0;
    end else begin
      sel_r      <= sel_nxt;
      sel_done_r <= sel_done_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Option timing
  always_comb begin
    case (OPTION)
      dklr_pkg::DKLR_OPT_001: begin
        dly_cyc = sel_r ? DLY_SEL1 : DLY_SEL0;
        rel_cyc = ONE;
      end
      dklr_pkg::DKLR_OPT_052: begin
        dly_cyc = DLY_05X;
        rel_cyc = REL_052;
      end
      dklr_pkg::DKLR_OPT_053: begin
        dly_cyc = DLY_05X;
        rel_cyc = REL_053;
      end
      dklr_pkg::DKLR_OPT_064: begin
        dly_cyc = DLY_064;
        rel_cyc = REL_064;
      end
      default: begin
        dly_cyc = DLY_002;
        rel_cyc = REL_002;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      dklr_pkg::DKLR_IDLE: begin
        cnt_nxt = '0;
        if (both_low && !factory_pin_a && !factory_pin_b) begin
          st_nxt  = dklr_pkg::DKLR_TIMING;
          cnt_nxt = ONE;
        end
      end
      dklr_pkg::DKLR_TIMING: begin
        if (!both_low) begin
          st_nxt  = dklr_pkg::DKLR_IDLE;
          cnt_nxt = '0;
        end else if (cnt_r >= dly_cyc) begin
          st_nxt  = dklr_pkg::DKLR_ASSERT;
          cnt_nxt = ONE;
        end else begin
          cnt_nxt = cnt_r + ONE;
        end
      end
      dklr_pkg::DKLR_ASSERT: begin
        if (!both_low) begin
          st_nxt  = dklr_pkg::DKLR_IDLE;
          cnt_nxt = '0;
        end else if (OPTION != dklr_pkg::DKLR_OPT_001 && cnt_r >= rel_cyc) begin
          st_nxt  = dklr_pkg::DKLR_WAIT_REL;
          cnt_nxt = '0;
        end else if (OPTION != dklr_pkg::DKLR_OPT_001) begin
          cnt_nxt = cnt_r + ONE;
        end
      end
      dklr_pkg::DKLR_WAIT_REL: begin
        cnt_nxt = '0;
        if (!both_low) begin
          st_nxt = dklr_pkg::DKLR_IDLE;
        end
      end
      default: begin
        st_nxt  = dklr_pkg::DKLR_IDLE;
        cnt_nxt = '0;
      end
    endcase
    out_nxt.rst_low_o    = 1'b0;
    out_nxt.rst_low_oe_n = (st_nxt != dklr_pkg::DKLR_ASSERT);
    out_nxt.rst_high     = DUAL_OUT && (st_nxt == dklr_pkg::DKLR_ASSERT);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r  <= dklr_pkg::DKLR_IDLE;
      cnt_r <= '0;
      out_r <= 3'b010;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign reset_out_low_o    = out_r.rst_low_o;
  assign reset_out_low_oe_n = out_r.rst_low_oe_n;
  assign reset_out_high_pp  = out_r.rst_high;
  assign timer_state        = st_r;
endmodule // dklr_timer

/* File: test/dklr_chk.sv */
// Port checker for the dual key long press reset timer
`timescale 1ns/1ps
module dklr_chk (
  input wire logic                  core_clk,
  input wire logic                  rstn,
  input wire logic                  key_input_a_n,
  input wire logic                  key_input_b_n,
  input wire logic                  factory_pin_a,
  input wire logic                  reset_out_low_o,
  input wire logic                  reset_out_low_oe_n,
  input wire logic                  reset_out_high_pp,
  input wire dklr_pkg::dklr_state_e timer_state
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  drain_data_a:
    assert property (reset_out_low_o == 1'b0) else $error("drain data not low");
  out_pair_a:
    assert property (reset_out_high_pp == !reset_out_low_oe_n) else $error("outputs differ");
  out_state_a:
    assert property (reset_out_low_oe_n == (timer_state != dklr_pkg::DKLR_ASSERT))
      else $error("reset output and state disagree");
  from_timing_a:
    assert property ($fell(reset_out_low_oe_n) |-> $past(timer_state) == dklr_pkg::DKLR_TIMING)
      else $error("reset asserted without timing");
  auto_release_a:
    assert property ($fell(reset_out_low_oe_n) |-> ##[1:12] reset_out_low_oe_n)
      else $error("reset not released in time");
  key_up_a:
    assert property ((key_input_a_n || key_input_b_n) [*7] |-> reset_out_low_oe_n)
      else $error("reset held with a key up");
  wait_hold_a:
    assert property (timer_state == dklr_pkg::DKLR_WAIT_REL && !key_input_a_n
      && !key_input_b_n |=> timer_state != dklr_pkg::DKLR_ASSERT) else $error("re-asserted");
  test_block_a:
    assert property (factory_pin_a [*6] ##0 timer_state == dklr_pkg::DKLR_IDLE
      |=> timer_state == dklr_pkg::DKLR_IDLE) else $error("timing with test pin high");
endmodule // dklr_chk

/* File: test/dklr_keys.sv */
// Key switches and host reset input model
`timescale 1ns/1ps
module dklr_keys (
  input  wire logic press_a,
  input  wire logic press_b,
  input  wire logic oe_n,
  output logic      key_a_n,
  output logic      key_b_n,
  output logic      host_rst_n
);
  assign key_a_n = ~press_a;
  assign key_b_n = ~press_b;
  assign host_rst_n = oe_n ? 1'b1 : 1'b0;
endmodule // dklr_keys

/* File: test/dual_key_long_press_reset_timer_bench.sv */
// Self-checking bench for the dual key long press reset timer
`timescale 1ns/1ps
module dual_key_long_press_reset_timer_bench;
  // Short counts keep the run brief
  localparam int unsigned DLY = 50;
  localparam int unsigned REL = 10;
  logic core_clk, rstn, press_a, press_b, factory_pin_a, host_rst_n;
  logic key_input_a_n, key_input_b_n, reset_out_low_o, reset_out_low_oe_n;
  logic reset_out_high_pp;
  dklr_pkg::dklr_state_e timer_state;
  int num_errors = 0;
  int checks_done = 0;
  int n;
  ////////////////////////////////////////
  dklr_keys keys (.press_a, .press_b, .oe_n(reset_out_low_oe_n), .key_a_n(key_input_a_n),
    .key_b_n(key_input_b_n), .host_rst_n);
  // Strap and factory_pin_b tied low; factory_pin_a driven by the bench
  dklr_timer #(.DLY_002(DLY), .REL_002(REL)) dut (.core_clk, .rstn, .key_input_a_n,
    .key_input_b_n, .delay_sel(1'b0), .factory_pin_a, .factory_pin_b(1'b0),
    .reset_out_low_o, .reset_out_low_oe_n, .reset_out_high_pp, .timer_state);
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  ////////////////////////////////////////
  task automatic test_done();
    $display("Checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic keys_set(input logic a, input logic b);
    @(posedge core_clk);
    press_a <= a;
    press_b <= b;
  endtask
  // Bounded wait for the host line
  task automatic wait_rst(input logic lvl, input int lim);
    n = 0;
    while (host_rst_n !== lvl && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    chk("host wait", 1, n < lim);
    if (n >= lim) test_done();
  endtask
  ////////////////////////////////////////
  task automatic t_long();
    keys_set(1, 1);
    wait_rst(0, DLY + 20);
    chk("delay", 1, n >= DLY && n <= DLY + 8);
    chk("high out", 1, reset_out_high_pp);
  endtask
  task automatic t_auto();
    wait_rst(1, REL + 12);
    chk("release", 1, n + 1 >= REL && n <= REL + 2);
    repeat (2 * DLY) @(posedge core_clk);
    chk("no repeat", 1, host_rst_n);
    keys_set(0, 0);
    repeat (8) @(posedge core_clk);
  endtask
  task automatic t_early();
    keys_set(1, 1);
    wait_rst(0, DLY + 20);
    keys_set(1, 0);
    wait_rst(1, 9);
    chk("high out", 0, reset_out_high_pp);
    keys_set(0, 0);
    repeat (8) @(posedge core_clk);
  endtask
  task automatic t_abandon();
    keys_set(1, 1);
    repeat (DLY - 10) @(posedge core_clk);
    keys_set(1, 0);
    repeat (6) @(posedge core_clk);
    keys_set(1, 1);
    wait_rst(0, DLY + 20);
    chk("restart", 1, n >= DLY);
    keys_set(0, 0);
    repeat (8) @(posedge core_clk);
  endtask
  task automatic t_factory();
    @(posedge core_clk);
    factory_pin_a <= 1'b1;
    keys_set(1, 1);
    repeat (2 * DLY) @(posedge core_clk);
    chk("blocked", 1, host_rst_n);
    keys_set(0, 0);
    // Keys settle released before the pin drops, so no stray timing start
    repeat (8) @(posedge core_clk);
    factory_pin_a <= 1'b0;
    @(posedge core_clk);
  endtask
  ////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    press_a = 1'b0;
    press_b = 1'b0;
    factory_pin_a = 1'b0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    chk("idle line", 1, host_rst_n);
    t_long();
    t_auto();
    t_early();
    t_abandon();
    t_factory();
    test_done();
  end
endmodule // dual_key_long_press_reset_timer_bench

bind dklr_timer dklr_chk u_chk (.core_clk, .rstn, .key_input_a_n, .key_input_b_n,
  .factory_pin_a, .reset_out_low_o, .reset_out_low_oe_n, .reset_out_high_pp, .timer_state);
